// ===== hdl/iwd_decoder.sv
// Purpose: parse an io_space_descriptor byte stream, keep the windows,
//          and answer enabled i/o cycles with an input acknowledge
// Assumes: inputs synchronous to clk_sys; start bytes and length bytes
//          arrive least significant byte first
// Notes:   results are held until the next desc_start pulse

module iwd_decoder #(
  parameter int unsigned MAX_RANGES = iwd_pkg::MAX_RANGES_DOC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // descriptor byte stream
  input  wire logic                       desc_start,
  input  wire logic                       desc_valid,
  input  wire logic [iwd_pkg::BYTE_W-1:0] desc_byte,
  output logic                            desc_ready,
  // parse results
  output logic                            parse_done,
  output logic                            parse_error,
  output logic                            range_present,
  output logic [iwd_pkg::DEF_BUS_W-1:0]   bus_width,
  output logic [iwd_pkg::DEF_LINES_W-1:0] decoded_line_count,
  output logic [4:0]                      range_total,
  output logic                            start_present,
  output logic                            length_present,
  // window read port
  input  wire logic [3:0]                 win_sel,
  output logic [iwd_pkg::VAL_W-1:0]       win_start,
  output logic [iwd_pkg::VAL_W-1:0]       win_length,
  // i/o cycle side
  input  wire logic                       io_enable,
  input  wire logic [iwd_pkg::ADDR_W-1:0] io_addr,
  output logic                            input_ack
);
  import iwd_pkg::*;

  // refuse sizes the range counter and read port cannot hold
  if (MAX_RANGES < 1 || MAX_RANGES > MAX_RANGES_DOC) begin : g_chk
    $error("MAX_RANGES must lie between 1 and 16");
  end

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_DEF   = 7'b0000010,
    ST_RDESC = 7'b0000100,
    ST_FIELD = 7'b0001000,
    ST_CHECK = 7'b0010000,
    ST_DONE  = 7'b0100000,
    ST_ERR   = 7'b1000000
  } iwd_state_t;

  typedef struct packed {
    iwd_state_t                        st;
    logic                              rflag;
    logic [DEF_BUS_W-1:0]              bus;
    logic [DEF_LINES_W-1:0]            lines;
    logic [2:0]                        asz;
    logic [2:0]                        lsz;
    logic [4:0]                        nr;
    logic [4:0]                        idx;
    logic [3:0]                        bcnt;
    logic [VAL_W-1:0]                  acc_s;
    logic [VAL_W-1:0]                  acc_l;
    logic [VAL_W+1:0]                  sum;
    logic                              bad;
    logic [MAX_RANGES-1:0][VAL_W-1:0]  ws;
    logic [MAX_RANGES-1:0][VAL_W-1:0]  wl;
    logic [VAL_W-1:0]                  rs;
    logic [VAL_W-1:0]                  rl;
  } iwd_regs_t;

  iwd_regs_t q;
  iwd_regs_t d;

  logic [2:0]       b_asz;
  logic [2:0]       b_lsz;
  logic [3:0]       fld_bytes;
  logic [3:0]       lpos;
  logic [VAL_W-1:0] len_full;
  logic [VAL_W-1:0] true_len;
  logic [VAL_W+1:0] span_all;

  // byte counts of the two fields from the descriptor byte
  assign b_asz = iwd_size_bytes(desc_byte[RD_ASIZE_LO +: RD_SIZE_W]);
  assign b_lsz = iwd_size_bytes(desc_byte[RD_LSIZE_LO +: RD_SIZE_W]);
  assign fld_bytes = {1'b0, q.asz} + {1'b0, q.lsz};
  assign lpos = q.bcnt - {1'b0, q.asz};
  // length field with the byte now on the bus merged in
  always_comb begin
    len_full = q.acc_l;
    len_full[lpos[1:0]*BYTE_W +: BYTE_W] = desc_byte;
  end
  // an all-ones 4-byte length wraps to zero
  assign true_len = len_full + {{(VAL_W-1){1'b0}}, 1'b1};
  // full decoded space, 2^lines
  assign span_all = {{(VAL_W+1){1'b0}}, 1'b1} << q.lines;

  // parser next state
  always_comb begin
    d = q;
    case (q.st)
      ST_IDLE: begin
        if (desc_start) begin
          d.st = ST_DEF;
        end
      end
      ST_DEF: begin
        if (desc_valid) begin
          d.rflag = desc_byte[DEF_RANGE_BIT];
          d.bus   = desc_byte[DEF_BUS_LO +: DEF_BUS_W];
          d.lines = desc_byte[DEF_LINES_LO +: DEF_LINES_W];
          d.asz   = 3'h0;
          d.lsz   = 3'h0;
          d.nr    = 5'h00;
          d.sum   = '0;
          d.ws    = '0;
          d.wl    = '0;
          if (desc_byte[DEF_LINES_LO +: DEF_LINES_W] > LINES_MAX) begin
            d.st = ST_ERR;
          end else if (desc_byte[DEF_RANGE_BIT]) begin
            d.st = ST_RDESC;
          end else if (desc_byte[DEF_LINES_LO +: DEF_LINES_W]
                       == LINES_NONE) begin
            d.st = ST_ERR;
          end else begin
            d.st = ST_DONE;
          end
        end
      end
      ST_RDESC: begin
        if (desc_valid) begin
          d.nr   = {1'b0, desc_byte[RD_COUNT_LO +: RD_COUNT_W]}
                   + 5'h01;
          d.asz  = b_asz;
          d.lsz  = b_lsz;
          d.idx  = 5'h00;
          d.bcnt = 4'h0;
          d.acc_s = '0;
          d.acc_l = '0;
          d.bad  = 1'b0;
          if (b_asz == 3'h0 && b_lsz == 3'h0) begin
            d.st = ST_ERR;
          end else if (q.lines == LINES_NONE && b_lsz == 3'h0) begin
            d.st = ST_ERR;
          end else if ({1'b0, desc_byte[RD_COUNT_LO +: RD_COUNT_W]}
                       >= 5'(MAX_RANGES)) begin
            d.st = ST_ERR; // more ranges than storage
          end else begin
            d.st = ST_FIELD;
          end
        end
      end
      ST_FIELD: begin
        if (desc_valid) begin
          if (q.bcnt < {1'b0, q.asz}) begin
            d.acc_s[q.bcnt[1:0]*BYTE_W +: BYTE_W] = desc_byte;
          end else begin
            d.acc_l[lpos[1:0]*BYTE_W +: BYTE_W] = desc_byte;
          end
          d.bcnt = q.bcnt + 4'h1;
          if (q.bcnt + 4'h1 == fld_bytes) begin
            // store the finished field before the accumulators clear
            d.ws[q.idx[3:0]] = d.acc_s;
            if (q.lsz != 3'h0) begin
              // 4-byte all-ones wraps to a zero length
              d.wl[q.idx[3:0]] = true_len;
              d.sum = q.sum + {2'b00, true_len};
              if (true_len == '0) begin
                d.bad = 1'b1;
              end
            end else begin
              // no length: the range covers the full decoded space
              d.wl[q.idx[3:0]] = span_all[VAL_W-1:0];
            end
            d.bcnt  = 4'h0;
            d.acc_s = '0;
            d.acc_l = '0;
            d.idx   = q.idx + 5'h01;
            if (q.idx + 5'h01 == q.nr) begin
              d.st = ST_CHECK;
            end
          end
        end
      end
      ST_CHECK: begin
        // a length sum beyond 2^lines could not be addressed at all
        if (q.bad) begin
          d.st = ST_ERR;
        end else if (q.lines != LINES_NONE && q.sum > span_all) begin
          d.st = ST_ERR;
        end else begin
          d.st = ST_DONE;
        end
      end
      ST_DONE, ST_ERR: begin
        if (desc_start) begin
          d.st = ST_DEF;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (desc_start && q.st != ST_IDLE) begin
      d.st = ST_DEF; // a new descriptor always restarts the parse
    end
    // registered read port, no window shown after an error
    d.rs = '0;
    d.rl = '0;
    if (d.st == ST_DONE && {1'b0, win_sel} < d.nr) begin
      d.rs = d.ws[win_sel];
      d.rl = d.wl[win_sel];
    end
  end

  // single state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // per-range hit against the low decoded address lines
  // limitation: upper lines are ignored, so every alias the host
  // enables is answered; keeping aliases apart is the host's job
  logic [MAX_RANGES-1:0] hit;
  logic [VAL_W-1:0]      amask;
  logic [VAL_W-1:0]      aoff;
  assign amask = span_all[VAL_W-1:0] - {{(VAL_W-1){1'b0}}, 1'b1};
  assign aoff  = {{(VAL_W-ADDR_W){1'b0}}, io_addr} & amask;

  for (genvar gi = 0; gi < MAX_RANGES; gi++) begin : g_hit
    logic [VAL_W-1:0] base;
    logic [VAL_W-1:0] rel;
    assign base = q.ws[gi] & amask;
    assign rel  = aoff - base;
    assign hit[gi] = (5'(gi) < q.nr) && (aoff >= base)
                     && (rel < q.wl[gi]);
  end

  // acknowledge: zero-line cards answer every alias
  always_comb begin
    input_ack = 1'b0;
    if (io_enable && q.st == ST_DONE) begin
      if (q.lines == LINES_NONE || !q.rflag) begin
        input_ack = 1'b1;
      end else begin
        input_ack = |hit;
      end
    end
  end

  // status straight from the state register, no extra latency
  assign desc_ready     = (q.st == ST_DEF) || (q.st == ST_RDESC)
                          || (q.st == ST_FIELD);
  assign parse_done     = (q.st == ST_DONE);
  assign parse_error    = (q.st == ST_ERR);
  assign range_present  = q.rflag;
  assign bus_width      = q.bus;
  assign decoded_line_count = q.lines;
  assign range_total    = q.nr;
  assign start_present  = (q.asz != 3'h0);
  assign length_present = (q.lsz != 3'h0);
  assign win_start      = q.rs;
  assign win_length     = q.rl;
endmodule : iwd_decoder

// ===== hdl/iwd_pkg.sv
// Purpose: constants for the i/o space descriptor decoder
// Assumes: one system clock, descriptor bytes arrive one per strobe
// Notes:   field positions of the definition and range descriptor bytes
package iwd_pkg;
  // definition byte layout
  localparam int unsigned DEF_RANGE_BIT  = 7;
  localparam int unsigned DEF_BUS_LO     = 5;
  localparam int unsigned DEF_BUS_W      = 2;
  localparam int unsigned DEF_LINES_LO   = 0;
  localparam int unsigned DEF_LINES_W    = 5;
  // range descriptor byte layout
  localparam int unsigned RD_COUNT_LO    = 0;
  localparam int unsigned RD_COUNT_W     = 4;
  localparam int unsigned RD_ASIZE_LO    = 4;
  localparam int unsigned RD_LSIZE_LO    = 6;
  localparam int unsigned RD_SIZE_W      = 2;
  // decoded line count limits
  localparam logic [4:0]  LINES_NONE     = 5'h00;
  localparam logic [4:0]  LINES_MAX      = 5'h1A;
  localparam int unsigned ADDR_W         = 26;
  localparam int unsigned MAX_RANGES_DOC = 16;
  localparam int unsigned VAL_W          = 32;
  localparam int unsigned BYTE_W         = 8;
  localparam logic [2:0]  FIELD_MAX_B    = 3'h4;

  // size code to byte count: absent, one, two, four bytes
  function automatic logic [2:0] iwd_size_bytes(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      2'h1:    r = 3'h1;
      2'h2:    r = 3'h2;
      2'h3:    r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : iwd_size_bytes
endpackage : iwd_pkg

// ===== testbench/iwd_decoder_props.sv
// Purpose: port-level checks for the descriptor decoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every iwd_decoder instance
module iwd_decoder_props
  import iwd_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       desc_start,
  input wire logic                       desc_ready,
  input wire logic                       parse_done,
  input wire logic                       parse_error,
  input wire logic                       range_present,
  input wire logic [iwd_pkg::DEF_LINES_W-1:0] decoded_line_count,
  input wire logic [4:0]                 range_total,
  input wire logic                       start_present,
  input wire logic                       length_present,
  input wire logic [3:0]                 win_sel,
  input wire logic [iwd_pkg::VAL_W-1:0]  win_start,
  input wire logic [iwd_pkg::VAL_W-1:0]  win_length,
  input wire logic                       io_enable,
  input wire logic                       input_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // answering side: ack only inside an enabled cycle with a window
  a_ack_idle: assert property (!io_enable |-> !input_ack)
    else $error("ack outside an enabled cycle");
  a_ack_nowin: assert property (!parse_done |-> !input_ack)
    else $error("ack without a valid window");
  a_ack_all: assert property (parse_done && io_enable &&
    (!range_present || decoded_line_count == LINES_NONE) |-> input_ack)
    else $error("card failed to answer every address");
  // parse results
  a_flag_excl: assert property (!(parse_done && parse_error))
    else $error("done and error together");
  a_line_limit: assert property (
    parse_done |-> decoded_line_count <= LINES_MAX)
    else $error("reserved line count accepted");
  a_count_span: assert property (parse_done |-> (range_present ?
    range_total inside {[5'h01:5'h10]} : range_total == 5'h00))
    else $error("range total out of span");
  a_size_pair: assert property (parse_done && range_present |->
    start_present || length_present)
    else $error("both field sizes absent");
  a_len_nz: assert property (parse_done && $past(parse_done) &&
    range_present && $stable(win_sel) && {1'b0, win_sel} < range_total
    |-> win_length != '0)
    else $error("zero window length");
  a_err_nowin: assert property (parse_error && $past(parse_error)
    |-> win_start == '0)
    else $error("window shown after error");
  a_err_hold: assert property (parse_error && !desc_start
    |=> parse_error)
    else $error("error flag dropped");
  a_ready_done: assert property (parse_done |-> !desc_ready)
    else $error("bytes accepted after done");

  c_range_done: cover property (parse_done && range_present);
  c_error:      cover property (parse_error);
  c_ack:        cover property (input_ack);
endmodule : iwd_decoder_props

bind iwd_decoder iwd_decoder_props chk_u (.*);

// ===== testbench/iwd_host_model.sv
// Purpose: host socket side issuing enabled i/o cycles
// Assumes: one enabled cycle per call, driven after the falling edge
// Notes:   address is inverted when idle so stale values never match
module iwd_host_model (
  input  wire logic                       clk_sys,
  input  wire logic                       input_ack,
  output logic                            io_enable,
  output logic [iwd_pkg::ADDR_W-1:0]      io_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_enable = 1'b0;
    io_addr   = '0;
  end
  // card enable across the window, upper lines free for aliases
  task automatic cycle(input logic [iwd_pkg::ADDR_W-1:0] a,
                       output logic ack);
    @(negedge clk_sys);
    io_addr   = a;
    io_enable = 1'b1;
    @(posedge clk_sys);
    ack = input_ack;
    @(negedge clk_sys);
    io_enable = 1'b0;
    io_addr   = ~a;
  endtask : cycle
endmodule : iwd_host_model

// ===== testbench/tb_iwd_decoder.sv
// Purpose: self-checking bench for the descriptor decoder
// Assumes: bytes least significant first, inputs moved at falling edge
// Notes:   host side is the partner model, probed per enabled cycle
module tb_iwd_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_n, desc_start, desc_valid, desc_ready;
  logic        parse_done, parse_error, range_present;
  logic        start_present, length_present, io_enable, input_ack;
  logic [7:0]  desc_byte;
  logic [1:0]  bus_width;
  logic [4:0]  decoded_line_count, range_total;
  logic [3:0]  win_sel;
  logic [31:0] win_start, win_length;
  logic [25:0] io_addr;
  int          n_fail, comparisons;

  iwd_decoder dut_u (.*);
  iwd_host_model host_u (.clk_sys, .input_ack, .io_enable, .io_addr);

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // restart a parse, hand over bytes, then wait for a verdict
  task automatic parse(input logic [7:0] b[$]);
    int k;
    @(negedge clk_sys);
    desc_start = 1'b1;
    @(negedge clk_sys);
    desc_start = 1'b0;
    foreach (b[i]) begin
      desc_valid = 1'b1;
      desc_byte  = b[i];
      for (k = 0; k < 20 && desc_ready !== 1'b1; k++) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    desc_valid = 1'b0;
    for (k = 0; k < 20 && !(parse_done | parse_error); k++)
      @(negedge clk_sys);
  endtask : parse

  task automatic res(input string nm, input logic d, input logic e);
    chk("parse_done", 32'(d), 32'(parse_done));
    chk("parse_error", 32'(e), 32'(parse_error));
    $display("test %s ended", nm);
  endtask : res

  task automatic probe(input logic [25:0] a, input logic e);
    logic ack;
    host_u.cycle(a, ack);
    chk("input_ack", 32'(e), 32'(ack));
  endtask : probe

  // window read port answers one cycle after the select moves
  task automatic win(input logic [3:0] s, input logic [31:0] st,
                     input logic [31:0] ln);
    @(negedge clk_sys);
    win_sel = s;
    repeat (2) @(negedge clk_sys);
    chk("win_start", st, win_start);
    chk("win_length", ln, win_length);
  endtask : win

  // a rejected descriptor gives no answer at all
  task automatic bad(input string nm);
    res(nm, 1'b0, 1'b1);
    probe(26'h0000010, 1'b0);
  endtask : bad

  // watchdog sized well above the whole sequence
  initial begin
    repeat (6000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  initial begin
    {rst_n, desc_start, desc_valid, desc_byte, win_sel} = '0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    parse('{8'h25}); res("no_range", 1'b1, 1'b0);
    chk("range_present", 32'h0, 32'(range_present));
    chk("bus_width", 32'h1, 32'(bus_width));
    chk("lines", 32'h5, 32'(decoded_line_count));
    probe(26'h3FFFFFF, 1'b1);
    parse('{8'h85, 8'h50, 8'h10, 8'h03}); res("one", 1'b1, 1'b0);
    chk("range_present", 32'h1, 32'(range_present));
    chk("start_present", 32'h1, 32'(start_present));
    chk("length_present", 32'h1, 32'(length_present));
    chk("range_total", 32'h1, 32'(range_total));
    win(4'h0, 32'h10, 32'h4);
    probe(26'h0000013, 1'b1);
    probe(26'h0000014, 1'b0);
    probe(26'h000000F, 1'b0);
    probe(26'h0002010, 1'b1);
    parse('{8'h84, 8'h61, 8'h00, 8'h00, 8'h03, 8'h04, 8'h00, 8'h07});
    res("two", 1'b1, 1'b0);
    chk("range_total", 32'h2, 32'(range_total));
    win(4'h1, 32'h4, 32'h8);
    probe(26'h000000B, 1'b1);
    probe(26'h000000C, 1'b0);
    parse('{8'h80, 8'hC0, 8'h0F, 8'h00, 8'h00, 8'h00});
    res("zero_lines", 1'b1, 1'b0);
    win(4'h0, 32'h0, 32'h10);
    probe(26'h3ABCDEF, 1'b1);
    probe(26'h0000040, 1'b1);
    parse('{8'h83, 8'h40, 8'h05});
    res("len_only", 1'b1, 1'b0);
    chk("start_present", 32'h0, 32'(start_present));
    chk("length_present", 32'h1, 32'(length_present));
    win(4'h0, 32'h0, 32'h6);
    probe(26'h0000028, 1'b1);
    probe(26'h000002D, 1'b1);
    probe(26'h000002E, 1'b0);
    parse('{8'h84, 8'h10, 8'h20});
    res("start_only", 1'b1, 1'b0);
    chk("start_present", 32'h1, 32'(start_present));
    chk("length_present", 32'h0, 32'(length_present));
    win(4'h0, 32'h20, 32'h10);
    probe(26'h000002F, 1'b1);
    probe(26'h000003F, 1'b1);
    parse('{8'h1B}); bad("lines27");
    parse('{8'h1F}); bad("lines31");
    parse('{8'h00}); bad("no_range_zero");
    parse('{8'h85, 8'h00}); bad("sizes_zero");
    parse('{8'h80, 8'h10, 8'h20}); bad("no_length");
    parse('{8'h82, 8'h40, 8'h07}); bad("too_long");
    parse('{8'h85, 8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    bad("zero_length");
    wrap_up();
  end
endmodule : tb_iwd_decoder
